// ==== design/olmr_top.sv ====
// one-line-mode configuration three and four port routing
`timescale 1ns/1ps
`include "olmr_cfg.svh"
module olmr_top
(
  // clock, enable, reset
  input  wire logic       clk,
  input  wire logic       ce,
  input  wire logic       reset_n,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // primary serial port
  input  wire logic       primary_port_bit_clock,
  input  wire logic       primary_port_frame_clock,
  output logic            primary_port_serial_out,
  // auxiliary serial port
  input  wire logic       aux_port_bit_clock,
  input  wire logic       aux_port_frame_clock,
  output logic            aux_port_serial_out,
  // serial sources
  input  wire logic       conv_serial_in,
  input  wire logic       rx_audio_serial_in,
  // status
  output logic            config_error,
  output logic            transfer_active
);
  import olmr_pkg::*;

  // ===========================================
  // registers and state
  logic [7:0]  functional_mode_control;
  logic [7:0]  interface_format_control;
  logic [7:0]  miscellaneous_port_control;
  olmr_state_t state;
  olmr_state_t next_state;
  logic        conv_dly;
  logic        rx_dly;

  // ===========================================
  // pin synchronisers
  localparam int NPIN = 6;
  wire [NPIN-1:0] pins = {rx_audio_serial_in, conv_serial_in,
                          aux_port_frame_clock, aux_port_bit_clock,
                          primary_port_frame_clock, primary_port_bit_clock};
  olmr_edge_t     pin_e [NPIN];

  generate
    for (genvar i = 0; i < NPIN; i++)
    begin : g_sync
      olmr_sync u_sync
      (
        .clk     (clk),
        .ce      (ce),
        .reset_n (reset_n),
        .pin     (pins[i]),
        .edge_o  (pin_e[i])
      );
    end
  endgenerate

  wire p_bclk_rise = pin_e[0].rise;
  wire p_bclk_fall = pin_e[0].fall;
  wire p_lrck_rise = pin_e[1].rise;
  wire a_bclk_rise = pin_e[2].rise;
  wire a_bclk_fall = pin_e[2].fall;
  wire a_lrck_rise = pin_e[3].rise;
  wire conv_bit    = pin_e[4].lvl;
  wire rx_bit      = pin_e[5].lvl;

  // ===========================================
  // clock measurement
  olmr_meas_t p_meas;
  olmr_meas_t a_meas;

  olmr_ratio u_p_ratio
  (
    .clk       (clk),
    .ce        (ce),
    .reset_n   (reset_n),
    .bclk_rise (p_bclk_rise),
    .lrck_rise (p_lrck_rise),
    .meas      (p_meas)
  );

  olmr_ratio u_a_ratio
  (
    .clk       (clk),
    .ce        (ce),
    .reset_n   (reset_n),
    .bclk_rise (a_bclk_rise),
    .lrck_rise (a_lrck_rise),
    .meas      (a_meas)
  );

  // ===========================================
  // field decode
  wire [1:0] p_spd  = functional_mode_control[`OLMR_PSPD];
  wire [1:0] a_spd  = functional_mode_control[`OLMR_ASPD];
  wire [1:0] csel   = functional_mode_control[`OLMR_CSEL];
  wire [1:0] cap_ol = interface_format_control[`OLMR_CAPOL];
  wire [1:0] pb_ol  = interface_format_control[`OLMR_PBOL];
  wire [1:0] dif    = interface_format_control[`OLMR_DIF];
  wire       p_mst  = miscellaneous_port_control[`OLMR_PMST];
  wire       ext_s  = miscellaneous_port_control[`OLMR_EXTS];
  wire       cfg3   = (csel == `OLMR_CSEL_CFG3);
  wire       cfg4   = (csel == `OLMR_CSEL_CFG4);

  // measured speed class must fall in a band and match the field
  function automatic logic speed_ok(input logic [1:0] fld,
                                    input olmr_meas_t m);
    speed_ok = (fld != SPD_NONE) && (m.speed == olmr_speed_t'(fld));
  endfunction

  // one-line field holds off or the first mode
  function automatic logic ol_basic(input logic [1:0] fld);
    ol_basic = (fld == `OLMR_OL_NONE) || (fld == `OLMR_OL_ONE);
  endfunction

  // ===========================================
  // config three check
  wire c3_fields = (p_spd == a_spd)
                 && speed_ok(p_spd, p_meas) && speed_ok(a_spd, a_meas)
                 && ol_basic(cap_ol)
                 && ol_basic(pb_ol)
                 && p_mst
                 && ext_s;
  wire c3_any_ol = (cap_ol != `OLMR_OL_NONE) || (pb_ol != `OLMR_OL_NONE);
  wire c3_plain  = (p_meas.ratio == RAT_64) && (a_meas.ratio == RAT_64);
  wire c3_one    = (p_meas.ratio == RAT_128)
                 && (p_spd == SPD_SINGLE) && (a_meas.ratio == RAT_64);
  wire c3_ok     = cfg3 && c3_fields && (c3_any_ol ? c3_one : c3_plain);

  // ===========================================
  // config four check
  wire c4_fields = speed_ok(p_spd, p_meas) && speed_ok(a_spd, a_meas)
                 && ol_basic(cap_ol)
                 && (pb_ol != 2'b11)
                 && p_mst
                 && !ext_s;
  wire c4_p_ok   = (pb_ol == `OLMR_OL_NONE) ? (p_meas.ratio == RAT_64) :
                   (pb_ol == `OLMR_OL_ONE)  ? (p_meas.ratio == RAT_128 &&
                                               p_spd != SPD_QUAD) :
                   (p_meas.ratio == RAT_256 && p_spd == SPD_SINGLE);
  wire c4_a_ok   = (cap_ol == `OLMR_OL_NONE) ? (a_meas.ratio == RAT_64) :
                   (a_meas.ratio == RAT_128 && a_spd == SPD_SINGLE);
  wire c4_ok     = cfg4 && c4_fields && c4_p_ok && c4_a_ok;

  // ===========================================
  // overall result
  wire cfg_ok    = c3_ok || c4_ok;
  wire meas_seen = p_meas.seen && a_meas.seen;

  // ===========================================
  // register port
  wire wr_fm = reg_wr && (reg_addr == `OLMR_ADDR_FMODE);
  wire wr_if = reg_wr && (reg_addr == `OLMR_ADDR_IFMT);
  wire wr_mc = reg_wr && (reg_addr == `OLMR_ADDR_MISC);
  wire any_wr = wr_fm || wr_if || wr_mc;

  // ===========================================
  // read path
  logic [7:0] next_rdata;
  wire  [7:0] status = {config_error, transfer_active,
                        p_meas.ratio, a_meas.ratio,
                        p_meas.seen, a_meas.seen};

  always_comb
  begin
    if (reg_addr == `OLMR_ADDR_FMODE)
      next_rdata = functional_mode_control;
    else if (reg_addr == `OLMR_ADDR_IFMT)
      next_rdata = interface_format_control;
    else if (reg_addr == `OLMR_ADDR_MISC)
      next_rdata = miscellaneous_port_control;
    else if (reg_addr == `OLMR_ADDR_STAT)
      next_rdata = status;
    else
      next_rdata = 8'h00;
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      functional_mode_control    <= `OLMR_FMODE_RST;
      interface_format_control   <= `OLMR_IFMT_RST;
      miscellaneous_port_control <= `OLMR_MISC_RST;
      reg_rdata                  <= 8'h00;
    end
    else if (ce)
    begin
      if (wr_fm)
        functional_mode_control <= reg_wdata;
      if (wr_if)
        interface_format_control <= reg_wdata;
      if (wr_mc)
        miscellaneous_port_control <= reg_wdata;
      reg_rdata <= next_rdata;
    end
  end

  // ===========================================
  // transfer state machine
  always_comb
  begin
    next_state = state;
    case (state)
      ST_CHECK:
        if (meas_seen)
          next_state = cfg_ok ? ST_RUN : ST_FAULT;
      ST_RUN:
        if (!cfg_ok)
          next_state = ST_FAULT;
      ST_FAULT:
        if (cfg_ok)
          next_state = ST_RUN;
      default:
        next_state = ST_CHECK;
    endcase
    if (any_wr)
      next_state = ST_CHECK;
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      state <= ST_CHECK;
    else if (ce)
      state <= next_state;
  end

  assign transfer_active = (state == ST_RUN);
  assign config_error    = (state == ST_FAULT);

  // ===========================================
  // routing and framing
  // delay format always on received audio, on the converter path only outside one-line framing
  wire conv_delay = (dif == `OLMR_DIF_DELAY) && (cap_ol == `OLMR_OL_NONE);
  wire rx_delay   = (dif == `OLMR_DIF_DELAY);
  // converter stream follows the port that carries it
  wire conv_fall  = cfg4 ? a_bclk_fall : p_bclk_fall;
  wire conv_val   = conv_delay ? conv_dly : conv_bit;
  wire rx_val     = rx_delay ? rx_dly : rx_bit;
  // config three carries received audio on aux, config four drops it
  wire next_aux   = cfg4 ? conv_val : rx_val;

  // one-bit delay stages for the delay format
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      conv_dly <= 1'b0;
      rx_dly   <= 1'b0;
    end
    else if (ce)
    begin
      if (conv_fall)
        conv_dly <= conv_bit;
      if (a_bclk_fall)
        rx_dly <= rx_bit;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      primary_port_serial_out <= 1'b0;
      aux_port_serial_out     <= 1'b0;
    end
    else if (ce)
    begin
      if (!transfer_active)
      begin
        primary_port_serial_out <= 1'b0;
        aux_port_serial_out     <= 1'b0;
      end
      else
      begin
        if (p_bclk_fall)
          primary_port_serial_out <= cfg3 ? conv_val : 1'b0;
        if (a_bclk_fall)
          aux_port_serial_out <= next_aux;
      end
    end
  end
endmodule

// ==== design/olmr_cfg.svh ====
// constants for the one-line-mode port routing block
`ifndef OLMR_CFG_SVH
`define OLMR_CFG_SVH

// register offsets
`define OLMR_ADDR_FMODE 8'h03
`define OLMR_ADDR_IFMT  8'h04
`define OLMR_ADDR_MISC  8'h05
`define OLMR_ADDR_STAT  8'h06

// reset values
`define OLMR_FMODE_RST 8'h00
`define OLMR_IFMT_RST  8'h00
`define OLMR_MISC_RST  8'h00

// functional mode fields
`define OLMR_PSPD 7:6
`define OLMR_ASPD 5:4
`define OLMR_CSEL 3:2

// interface format fields
`define OLMR_CAPOL 7:6
`define OLMR_PBOL  5:4
`define OLMR_DIF   1:0

// miscellaneous fields
`define OLMR_PMST 7
`define OLMR_AMST 6
`define OLMR_EXTS 5

// field codes
`define OLMR_CSEL_CFG3 2'b00
`define OLMR_CSEL_CFG4 2'b10
`define OLMR_OL_NONE   2'b00
`define OLMR_OL_ONE    2'b01
`define OLMR_OL_TWO    2'b10
`define OLMR_DIF_DELAY 2'b01

// bit clocks per frame
`define OLMR_BITS_64  9'd64
`define OLMR_BITS_128 9'd128
`define OLMR_BITS_256 9'd256

// frame rates in hz and clock rate
`define OLMR_CLK_HZ   50000000
`define OLMR_SSM_LO   32000
`define OLMR_SSM_HI   48000
`define OLMR_DSM_LO   64000
`define OLMR_DSM_HI   96000
`define OLMR_QSM_LO   176400
`define OLMR_QSM_HI   192000
`define OLMR_TOL_CYC  2

// frame period limits in clk cycles
`define OLMR_SSM_MIN ((`OLMR_CLK_HZ / `OLMR_SSM_HI) - `OLMR_TOL_CYC)
`define OLMR_SSM_MAX ((`OLMR_CLK_HZ / `OLMR_SSM_LO) + `OLMR_TOL_CYC)
`define OLMR_DSM_MIN ((`OLMR_CLK_HZ / `OLMR_DSM_HI) - `OLMR_TOL_CYC)
`define OLMR_DSM_MAX ((`OLMR_CLK_HZ / `OLMR_DSM_LO) + `OLMR_TOL_CYC)
`define OLMR_QSM_MIN ((`OLMR_CLK_HZ / `OLMR_QSM_HI) - `OLMR_TOL_CYC)
`define OLMR_QSM_MAX ((`OLMR_CLK_HZ / `OLMR_QSM_LO) + `OLMR_TOL_CYC)

`endif

// ==== design/olmr_pkg.sv ====
// types for the one-line-mode port routing block
package olmr_pkg;

  typedef enum logic [1:0]
  {
    SPD_SINGLE = 2'b00,
    SPD_DOUBLE = 2'b01,
    SPD_QUAD   = 2'b10,
    SPD_NONE   = 2'b11
  } olmr_speed_t;

  typedef enum logic [1:0]
  {
    RAT_64    = 2'b00,
    RAT_128   = 2'b01,
    RAT_256   = 2'b10,
    RAT_OTHER = 2'b11
  } olmr_ratio_t;

  typedef enum logic [1:0]
  {
    ST_CHECK = 2'b00,
    ST_RUN   = 2'b01,
    ST_FAULT = 2'b10
  } olmr_state_t;

  typedef struct packed
  {
    logic        seen;
    olmr_ratio_t ratio;
    olmr_speed_t speed;
  } olmr_meas_t;

  typedef struct packed
  {
    logic lvl;
    logic rise;
    logic fall;
  } olmr_edge_t;

endpackage

// ==== design/olmr_sync.sv ====
// two-stage synchroniser with edge detection
`timescale 1ns/1ps
module olmr_sync
(
  // clock, enable, reset
  input  wire logic                clk,
  input  wire logic                ce,
  input  wire logic                reset_n,
  // pin and result
  input  wire logic                pin,
  output olmr_pkg::olmr_edge_t     edge_o
);
  import olmr_pkg::*;

  logic [2:0] stage;

  // ===========================================
  // sampling
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      stage <= 3'h0;
    else if (ce)
      stage <= {stage[1:0], pin};
  end

  assign edge_o.lvl  = stage[1];
  assign edge_o.rise = stage[1] & ~stage[2];
  assign edge_o.fall = ~stage[1] & stage[2];
endmodule

// ==== design/olmr_ratio.sv ====
// bit-clock ratio and frame-rate measurement of one port
`timescale 1ns/1ps
`include "olmr_cfg.svh"
module olmr_ratio
(
  // clock, enable, reset
  input  wire logic               clk,
  input  wire logic               ce,
  input  wire logic               reset_n,
  // edges of the port clocks
  input  wire logic               bclk_rise,
  input  wire logic               lrck_rise,
  // result
  output olmr_pkg::olmr_meas_t    meas
);
  import olmr_pkg::*;

  logic [8:0]  bits;
  logic [10:0] cyc;
  logic        started;
  olmr_ratio_t next_ratio;
  olmr_speed_t next_speed;

  // ===========================================
  // classification
  function automatic olmr_speed_t speed_of(input logic [10:0] c);
    if (c >= 11'(`OLMR_SSM_MIN) && c <= 11'(`OLMR_SSM_MAX))
      speed_of = SPD_SINGLE;
    else if (c >= 11'(`OLMR_DSM_MIN) && c <= 11'(`OLMR_DSM_MAX))
      speed_of = SPD_DOUBLE;
    else if (c >= 11'(`OLMR_QSM_MIN) && c <= 11'(`OLMR_QSM_MAX))
      speed_of = SPD_QUAD;
    else
      speed_of = SPD_NONE;
  endfunction

  assign next_ratio = (bits == `OLMR_BITS_64)  ? RAT_64 :
                      (bits == `OLMR_BITS_128) ? RAT_128 :
                      (bits == `OLMR_BITS_256) ? RAT_256 : RAT_OTHER;
  assign next_speed = speed_of(cyc);

  // ===========================================
  // counting between frame-clock rising edges
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      bits    <= 9'h000;
      cyc     <= 11'h000;
      started <= 1'b0;
      meas    <= '{seen: 1'b0, ratio: RAT_OTHER, speed: SPD_NONE};
    end
    else if (ce)
    begin
      if (lrck_rise)
      begin
        bits    <= {8'h00, bclk_rise};
        cyc     <= 11'h001;
        started <= 1'b1;
        if (started)
          meas <= '{seen: 1'b1, ratio: next_ratio, speed: next_speed};
      end
      else
      begin
        if (bclk_rise && bits != 9'h1ff)
          bits <= bits + 9'h001;
        if (cyc != 11'h7ff)
          cyc <= cyc + 11'h001;
      end
    end
  end
endmodule

// ==== verification/olmr_top_checker.sv ====
// assertions for the port routing block
`timescale 1ns/1ps
module olmr_top_checker
(
  // clock, enable, reset
  input wire logic       clk,
  input wire logic       ce,
  input wire logic       reset_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // outputs
  input wire logic       primary_port_serial_out,
  input wire logic       aux_port_serial_out,
  input wire logic       config_error,
  input wire logic       transfer_active
);
  // ====
  // register shadows
  logic [7:0] fm;
  logic [7:0] fi;
  logic [7:0] mc;
  wire        wr_ok = ce && reg_wr;
  wire        c3    = fm[3:2] == 2'b00;
  wire        c4    = fm[3:2] == 2'b10;
  wire        run   = transfer_active;
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      fm <= 8'h00;
      fi <= 8'h00;
      mc <= 8'h00;
    end
    else if (wr_ok)
    begin
      if (reg_addr == 8'h03) fm <= reg_wdata;
      if (reg_addr == 8'h04) fi <= reg_wdata;
      if (reg_addr == 8'h05) mc <= reg_wdata;
    end
  end
  // ====
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  chk_one_state: assert property (!(config_error && transfer_active))
    else $error("error and active both high");
  chk_fault_quiet: assert property (config_error && $past(config_error)
    |-> !primary_port_serial_out && !aux_port_serial_out)
    else $error("serial out moves in fault");
  chk_write_check: assert property (wr_ok && reg_addr inside {8'h03, 8'h04, 8'h05}
    |=> !config_error && !transfer_active)
    else $error("write did not restart check");
  chk_status_state: assert property (ce && reg_addr == 8'h06
    |=> reg_rdata[7] == $past(config_error)
    && reg_rdata[6] == $past(transfer_active))
    else $error("status state bits wrong");
  chk_cfg3_misc: assert property (run && c3 |-> mc[7] && mc[5])
    else $error("config three runs with bad control bits");
  chk_cfg3_modes: assert property (run && c3 |-> fi[7:6] != 2'b10
    && fi[5:4] != 2'b10 && fm[7:6] == fm[5:4])
    else $error("config three runs with bad modes");
  chk_cfg4_misc: assert property (run && c4
    |-> mc[7] && !mc[5] && fi[7:6] != 2'b10)
    else $error("config four runs with bad settings");
  chk_cfg4_quiet: assert property (run && $past(run) && c4
    |-> !primary_port_serial_out)
    else $error("primary out moves in config four");
  cover property (run && c3);
  cover property (run && c4);
  cover property ($rose(config_error));
endmodule

bind olmr_top olmr_top_checker chk_u
(
  .clk(clk), .ce(ce), .reset_n(reset_n), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .primary_port_serial_out(primary_port_serial_out),
  .aux_port_serial_out(aux_port_serial_out),
  .config_error(config_error), .transfer_active(transfer_active)
);

// ==== verification/olmr_host_port.sv ====
// serial port clock source of the audio processor
`timescale 1ns/1ps
module olmr_host_port
(
  // control
  input  wire logic        run,
  input  wire logic [15:0] half_ns,
  input  wire logic [15:0] ratio,
  // port clocks
  output logic             bclk,
  output logic             lrck
);
  int n;
  initial
  begin
    n = 0;
    forever
    begin
      if (!run)
      begin
        // clocks stand still between runs
        bclk = 1'b0;
        lrck = 1'b0;
        #10;
      end
      else
      begin
        #(half_ns) bclk = 1'b1;
        #(half_ns) bclk = 1'b0;
        n = (n + 1) % ratio;
        lrck = n < ratio / 2;
      end
    end
  end
endmodule

// ==== verification/olmr_top_test.sv ====
// self-checking bench for the port routing block
`timescale 1ns/1ps
module olmr_top_test;
  logic        clk, reset_n, reg_wr, pb, pl, po, ab, al, ao;
  logic        conv, rx, cerr, act, prun, arun, ce;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic [15:0] ph, pr, ah, ar;
  int          err_count, tests_run;
  olmr_host_port host_p (.run(prun), .half_ns(ph), .ratio(pr), .bclk(pb), .lrck(pl));
  olmr_host_port host_a (.run(arun), .half_ns(ah), .ratio(ar), .bclk(ab), .lrck(al));
  olmr_top dut_u
  (
    .clk(clk), .ce(ce), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .primary_port_bit_clock(pb),
    .primary_port_frame_clock(pl), .primary_port_serial_out(po),
    .aux_port_bit_clock(ab), .aux_port_frame_clock(al), .aux_port_serial_out(ao),
    .conv_serial_in(conv), .rx_audio_serial_in(rx), .config_error(cerr),
    .transfer_active(act)
  );
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ====
  // tasks
  task automatic conclude;
    if (err_count == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e)
    begin
      err_count++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmp1(input logic g, input logic e);
    cmp8({7'h00, g}, {7'h00, e});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    reg_addr = a;
    @(negedge clk);
    cmp8(reg_rdata, e);
  endtask
  task automatic scen(input logic [7:0] f, i, m, input logic [15:0] h1, r1, h2, r2,
                      input logic e);
    int k;
    ph = h1;
    pr = r1;
    ah = h2;
    ar = r2;
    conv = 1'b1;
    rx = 1'b1;
    wr(8'h03, f);
    wr(8'h04, i);
    wr(8'h05, m);
    repeat (4000) @(negedge clk);
    k = 0;
    while (!(cerr || act) && k < 4000)
    begin
      @(negedge clk);
      k++;
    end
    if (k >= 4000)
    begin
      err_count++;
      conclude();
    end
    cmp1(cerr, e);
    cmp1(act, !e);
    if (e)
    begin
      cmp1(po, 1'b0);
      cmp1(ao, 1'b0);
    end
  endtask
  task automatic route(input logic c, input logic r, input logic ep, input logic ea);
    conv = c;
    rx = r;
    repeat (200) @(negedge clk);
    cmp1(po, ep);
    cmp1(ao, ea);
  endtask
  // ====
  // sequence
  initial
  begin
    err_count = 0;
    tests_run = 0;
    reset_n = 1'b0;
    {reg_addr, reg_wdata, reg_wr, conv, rx, prun, arun} = 21'h0;
    {ph, pr, ah, ar} = {16'd200, 16'd64, 16'd200, 16'd64};
    ce = 1'b1;
    repeat (8) @(negedge clk);
    reset_n = 1'b1;
    rd(8'h03, 8'h00);
    rd(8'h04, 8'h00);
    rd(8'h05, 8'h00);
    // a write with the enable low must not land
    ce = 1'b0;
    wr(8'h03, 8'hff);
    ce = 1'b1;
    rd(8'h03, 8'h00);
    wr(8'h07, 8'hff);
    rd(8'h07, 8'h00);
    wr(8'h06, 8'hff);
    // idle status: both ratios unmeasured, nothing seen
    rd(8'h06, 8'h3c);
    prun = 1'b1;
    arun = 1'b1;
    scen(8'h00, 8'h00, 8'ha0, 200, 64, 200, 64, 0);
    rd(8'h06, 8'h43);
    route(1, 0, 1, 0);
    route(0, 1, 0, 1);
    scen(8'h00, 8'h00, 8'h20, 200, 64, 200, 64, 1);
    scen(8'h00, 8'h00, 8'h80, 200, 64, 200, 64, 1);
    scen(8'h00, 8'h40, 8'he0, 100, 128, 200, 64, 0);
    scen(8'h00, 8'h20, 8'ha0, 50, 256, 200, 64, 1);
    scen(8'h10, 8'h00, 8'ha0, 200, 64, 200, 64, 1);
    scen(8'h50, 8'h00, 8'ha0, 80, 64, 80, 64, 1);
    scen(8'h18, 8'h21, 8'hc0, 50, 256, 100, 64, 0);
    rd(8'h06, 8'h63);
    route(1, 0, 0, 1);
    route(0, 1, 0, 0);
    scen(8'h18, 8'h80, 8'h80, 50, 256, 100, 64, 1);
    scen(8'h18, 8'h40, 8'h80, 200, 64, 50, 128, 1);
    scen(8'h18, 8'h00, 8'ha0, 200, 64, 100, 64, 1);
    scen(8'h08, 8'h40, 8'h40, 200, 64, 100, 128, 1);
    scen(8'h08, 8'h40, 8'h80, 200, 64, 100, 128, 0);
    // reset in mid-run clears state, outputs and registers
    reset_n = 1'b0;
    repeat (8) @(negedge clk);
    cmp1(cerr, 1'b0);
    cmp1(act, 1'b0);
    cmp1(po, 1'b0);
    cmp1(ao, 1'b0);
    reset_n = 1'b1;
    rd(8'h05, 8'h00);
    conclude();
  end
endmodule
